// *** design/dtp_fifo.sv ***
// small valid/ready fifo
`timescale 1ns/1ns
`default_nettype none
module dtp_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= AW'(wr_ff + 1'b1);
      end
      if (pop) begin
        rd_ff <= AW'(rd_ff + 1'b1);
      end
      cnt_ff <= (AW+1)'(cnt_ff + push - pop);
    end
  end
endmodule
`default_nettype wire

// *** design/dtp_map.svh ***
// constants for the terminal payload port
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH
`define DTP_EDGES_DS3   11'h498
`define DTP_EDGES_G832  11'h432
`define DTP_EDGES_G751  11'h180
`define DTP_FIFO_DEPTH  8
`define DTP_FIFO_WIDTH  6
`define DTP_SYNC_RST    3'h0
`endif

// *** design/dtp_payload_port.sv ***
// terminal-side payload port of one framer channel
`timescale 1ns/1ns
`default_nettype none
`include "dtp_map.svh"
// What this block does
// - in ds3 nibble mode each outbound frame gets exactly 1176 nibble clock edges.
// - in e3 g.832 mode each outbound frame gets exactly 1074 nibble clock edges.
// - in e3 g.751 mode each outbound frame gets exactly 384 nibble clock edges.
// - outside hdlc serial mode payload bits leave on the receive clock rising edge.
// - outside hdlc mode the serial output is driven only while nibble select is low.
// - the shared serial pin carries payload in serial mode (held low while nibble select is high) and the idle flag in hdlc mode.
// - in hdlc mode the idle flag is high between packets.
// - idle flag together with the good check pulse can signal hdlc errors.
// - in serial mode the frame pulse lasts one bit on the first frame bit.
// - frame pulse timing follows serial or nibble operation.
// - the nibble clock derives from the chosen reference clock.
// - in nibble mode the frame pulse lasts one nibble on the first nibble.
module dtp_payload_port
  import dtp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire dtp_pkg::dtp_format_type format_sel,
  input  wire logic                    hdlc_mode,
  input  wire logic                    nibble_select,
  input  wire logic                    use_line_timing,
  input  wire logic                    tx_reference_clock_in,
  input  wire logic                    recovered_line_clock_in,
  input  wire logic                    send_check_sequence_in,
  input  wire logic                    rx_payload_clock,
  input  wire logic                    rx_bit_valid,
  input  wire logic                    rx_bit,
  input  wire logic                    rx_frame_start,
  input  wire logic                    rx_packet_active,
  input  wire logic                    rx_check_good,
  output logic                         rx_bit_ready,
  output logic                         tx_nibble_clock_out,
  output logic                         tx_frame_end_out,
  output logic                         tx_check_phase_out,
  output logic                         rx_serial_payload_out,
  output logic                         rx_hdlc_idle_flag_out,
  output logic                         good_check_sequence_pulse,
  output logic                         rx_frame_boundary_out,
  output logic [3:0]                   rx_nibble_data_out
);
  import dtp_pkg::*;
  // three-stage samplers for outside inputs
  logic [2:0] txr_ff;
  logic [2:0] lnc_ff;
  logic [2:0] rxc_ff;
  logic [2:0] fcs_ff;
  logic       txr_st_ff;
  logic       lnc_st_ff;
  logic       rxc_st_ff;
  logic       fcs_st_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      txr_ff <= `DTP_SYNC_RST;
      lnc_ff <= `DTP_SYNC_RST;
      rxc_ff <= `DTP_SYNC_RST;
      fcs_ff <= `DTP_SYNC_RST;
    end else begin
      txr_ff <= {txr_ff[1:0], tx_reference_clock_in};
      lnc_ff <= {lnc_ff[1:0], recovered_line_clock_in};
      rxc_ff <= {rxc_ff[1:0], rx_payload_clock};
      fcs_ff <= {fcs_ff[1:0], send_check_sequence_in};
    end
  end
  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      txr_st_ff <= 1'b0;
      lnc_st_ff <= 1'b0;
      rxc_st_ff <= 1'b0;
      fcs_st_ff <= 1'b0;
    end else begin
      if (txr_ff[1] == txr_ff[2]) txr_st_ff <= txr_ff[2];
      if (lnc_ff[1] == lnc_ff[2]) lnc_st_ff <= lnc_ff[2];
      if (rxc_ff[1] == rxc_ff[2]) rxc_st_ff <= rxc_ff[2];
      if (fcs_ff[1] == fcs_ff[2]) fcs_st_ff <= fcs_ff[2];
    end
  end
  wire txr_rise = (txr_ff[1] == txr_ff[2]) && txr_ff[2] && !txr_st_ff;
  wire lnc_rise = (lnc_ff[1] == lnc_ff[2]) && lnc_ff[2] && !lnc_st_ff;
  wire rxc_rise = (rxc_ff[1] == rxc_ff[2]) && rxc_ff[2] && !rxc_st_ff;
  wire rxc_fall = (rxc_ff[1] == rxc_ff[2]) && !rxc_ff[2] && rxc_st_ff;
  // transmit nibble clock: one edge out per four reference bits
  wire        ref_rise = use_line_timing ? lnc_rise : txr_rise;
  wire        nib_mode = nibble_select && !hdlc_mode;
  logic [1:0] div_ff;
  logic [10:0] edge_ff;
  logic       tnc_ff;
  logic       tfe_ff;
  logic       tcp_ff;
  logic [10:0] frame_edges;
  always_comb begin
    case (format_sel)
      DTP_FMT_DS3:  frame_edges = `DTP_EDGES_DS3;
      DTP_FMT_G832: frame_edges = `DTP_EDGES_G832;
      DTP_FMT_G751: frame_edges = `DTP_EDGES_G751;
      default:      frame_edges = `DTP_EDGES_DS3;
    endcase
  end
  wire nib_tick  = ref_rise && (div_ff == 2'h3);
  wire last_edge = (edge_ff == 11'(frame_edges - 11'h001));
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff  <= 2'h0;
      edge_ff <= 11'h000;
      tnc_ff  <= 1'b0;
      tfe_ff  <= 1'b0;
    end else begin
      if (ref_rise) div_ff <= 2'(div_ff + 2'h1);
      tnc_ff <= nib_mode && (div_ff[1] == 1'b0);
      if (!nib_mode) begin
        edge_ff <= 11'h000;
      end else if (nib_tick) begin
        edge_ff <= last_edge ? 11'h000 : 11'(edge_ff + 11'h001);
      end
      tfe_ff <= nib_mode && last_edge;
    end
  end
  // send-fcs is only meaningful in hdlc mode
  always_ff @(posedge clk) begin
    if (rst) tcp_ff <= 1'b0;
    else     tcp_ff <= hdlc_mode && fcs_st_ff;
  end
  assign tx_nibble_clock_out = tnc_ff;
  assign tx_frame_end_out    = tfe_ff;
  assign tx_check_phase_out  = tcp_ff;
  // independent tally of nibble clock rises between frame marks
  // the first mark after a mode change only arms the tally
  logic        tnc_d_ff;
  logic        tfe_d_ff;
  logic [10:0] rise_cnt_ff;
  logic        tally_ok_ff;
  wire tnc_up = tnc_ff && !tnc_d_ff;
  wire tfe_up = tfe_ff && !tfe_d_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      tnc_d_ff    <= 1'b0;
      tfe_d_ff    <= 1'b0;
      rise_cnt_ff <= 11'h000;
      tally_ok_ff <= 1'b0;
    end else begin
      tnc_d_ff <= tnc_ff;
      tfe_d_ff <= tfe_ff;
      if (!nib_mode) begin
        rise_cnt_ff <= 11'h000;
        tally_ok_ff <= 1'b0;
      end else if (tfe_up) begin
        rise_cnt_ff <= 11'h000;
        tally_ok_ff <= 1'b1;
      end else if (tnc_up) begin
        rise_cnt_ff <= 11'(rise_cnt_ff + 11'h001);
      end
    end
  end
  // receive path: bits buffered, drained one per receive clock rise
  logic       f_valid;
  logic       f_ready;
  logic [5:0] f_data;
  dtp_fifo #(.WIDTH(`DTP_FIFO_WIDTH), .DEPTH(`DTP_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_bit_valid),
    .in_ready  (rx_bit_ready),
    .in_data   ({4'h0, rx_frame_start, rx_bit}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  // stalls the source when the terminal clock is slow or stopped
  assign f_ready = rxc_rise;
  logic       ser_ff;
  logic       fb_ff;
  logic       idle_ff;
  logic       gcs_ff;
  logic [3:0] nib_sh_ff;
  logic [3:0] nib_ff;
  logic [1:0] bcnt_ff;
  logic       nfirst_ff;
  wire take = f_valid && f_ready;
  wire serial_on = !hdlc_mode && !nibble_select;
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_ff    <= 1'b0;
      fb_ff     <= 1'b0;
      bcnt_ff   <= 2'h0;
      nib_sh_ff <= 4'h0;
      nib_ff    <= 4'h0;
      nfirst_ff <= 1'b0;
    end else begin
      if (hdlc_mode) begin
        // same next value as the idle flag, so the pin never lags it
        ser_ff <= !rx_packet_active;
      end else if (!serial_on) begin
        ser_ff <= 1'b0;
      end else if (take) begin
        ser_ff <= f_data[0];
      end
      if (take) begin
        nib_sh_ff <= {nib_sh_ff[2:0], f_data[0]};
        bcnt_ff   <= 2'(bcnt_ff + 2'h1);
        if (bcnt_ff == 2'h0) nfirst_ff <= f_data[1];
        if (bcnt_ff == 2'h3) nib_ff <= {nib_sh_ff[2:0], f_data[0]};
      end
      // serial pulse spans one bit; nibble pulse one nibble
      if (nibble_select) begin
        if (take && bcnt_ff == 2'h3) fb_ff <= nfirst_ff;
      end else if (take) begin
        fb_ff <= f_data[1];
      end else if (rxc_fall && fb_ff && !f_valid) begin
        fb_ff <= 1'b0;
      end
    end
  end
  // idle high between packets; idle with good pulse flags an error
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_ff <= 1'b0;
      gcs_ff  <= 1'b0;
    end else begin
      idle_ff <= hdlc_mode && !rx_packet_active;
      gcs_ff  <= hdlc_mode && rx_check_good;
    end
  end
  assign rx_serial_payload_out     = ser_ff;
  assign rx_hdlc_idle_flag_out     = idle_ff;
  assign good_check_sequence_pulse = gcs_ff;
  assign rx_frame_boundary_out     = fb_ff;
  assign rx_nibble_data_out        = nib_ff;
  // checks
  a_serial_gated: assert property (@(posedge clk) disable iff (rst)
    (!hdlc_mode && nibble_select) |=> !rx_serial_payload_out)
    else $error("serial output driven in nibble mode");
  a_hdlc_pin_idle: assert property (@(posedge clk) disable iff (rst)
    hdlc_mode |=> (rx_serial_payload_out == rx_hdlc_idle_flag_out))
    else $error("shared pin not idle flag in hdlc");
  a_idle_level: assert property (@(posedge clk) disable iff (rst)
    (hdlc_mode && !rx_packet_active) |=> rx_hdlc_idle_flag_out)
    else $error("idle flag low between packets");
  a_good_pulse: assert property (@(posedge clk) disable iff (rst)
    (hdlc_mode && rx_check_good) |=> good_check_sequence_pulse)
    else $error("good check pulse missing");
  a_edge_bound: assert property (@(posedge clk) disable iff (rst)
    edge_ff < frame_edges)
    else $error("edge count past frame");
  a_edge_wrap: assert property (@(posedge clk) disable iff (rst)
    (nib_mode && nib_tick && last_edge) |=> (edge_ff == 11'h000))
    else $error("edge count did not wrap");
  a_frame_end: assert property (@(posedge clk) disable iff (rst)
    (nib_mode && last_edge) |=> tx_frame_end_out)
    else $error("frame end mark missing");
  a_ser_bit: assert property (@(posedge clk) disable iff (rst)
    (serial_on && take) |=> (rx_serial_payload_out == $past(f_data[0])))
    else $error("serial bit not presented");
  a_frame_pulse: assert property (@(posedge clk) disable iff (rst)
    (!nibble_select && take) |=> (rx_frame_boundary_out == $past(f_data[1])))
    else $error("frame pulse not aligned");
  // the tally catches a divider that slips a tick within a frame
  a_edge_tally: assert property (@(posedge clk) disable iff (rst)
    (tally_ok_ff && tfe_up) |-> (11'(rise_cnt_ff + 11'h001) == frame_edges))
    else $error("nibble clock rises per frame wrong");
  a_nck_quiet: assert property (@(posedge clk) disable iff (rst)
    !nib_mode |=> !tx_nibble_clock_out)
    else $error("nibble clock running outside nibble mode");
  a_fend_quiet: assert property (@(posedge clk) disable iff (rst)
    !nib_mode |=> !tx_frame_end_out)
    else $error("frame end mark outside nibble mode");
  a_ref_pick: assert property (@(posedge clk) disable iff (rst)
    !ref_rise |=> $stable(div_ff))
    else $error("divider moved without reference rise");
  a_check_gate: assert property (@(posedge clk) disable iff (rst)
    !hdlc_mode |=> !tx_check_phase_out)
    else $error("check phase shown outside hdlc");
  a_fcs_follow: assert property (@(posedge clk) disable iff (rst)
    (hdlc_mode && fcs_st_ff) |=> tx_check_phase_out)
    else $error("check phase not following send request");
  a_idle_off: assert property (@(posedge clk) disable iff (rst)
    !hdlc_mode |=> !rx_hdlc_idle_flag_out)
    else $error("idle flag high outside hdlc");
  a_good_off: assert property (@(posedge clk) disable iff (rst)
    !hdlc_mode |=> !good_check_sequence_pulse)
    else $error("good check pulse outside hdlc");
  a_stall_take: assert property (@(posedge clk) disable iff (rst)
    !rxc_rise |-> !take)
    else $error("bit taken without receive clock rise");
  a_ser_hold: assert property (@(posedge clk) disable iff (rst)
    (serial_on && !take) |=> $stable(rx_serial_payload_out))
    else $error("serial bit changed between clock rises");
  a_pulse_hold: assert property (@(posedge clk) disable iff (rst)
    (!nibble_select && !take && !rxc_fall) |=> $stable(rx_frame_boundary_out))
    else $error("serial frame pulse changed mid bit");
  a_nib_pulse: assert property (@(posedge clk) disable iff (rst)
    (nibble_select && take && bcnt_ff == 2'h3) |=>
      (rx_frame_boundary_out == $past(nfirst_ff)))
    else $error("nibble frame pulse not on first nibble");
  // limitation: pulse stands a whole nibble, even if the clock stops
  a_nib_hold: assert property (@(posedge clk) disable iff (rst)
    (nibble_select && !(take && bcnt_ff == 2'h3)) |=>
      $stable(rx_frame_boundary_out))
    else $error("nibble frame pulse changed mid nibble");
  a_nib_word: assert property (@(posedge clk) disable iff (rst)
    (nibble_select && !(take && bcnt_ff == 2'h3)) |=>
      $stable(rx_nibble_data_out))
    else $error("nibble data changed mid nibble");
  a_ser_nib_mode: assert property (@(posedge clk) disable iff (rst)
    (nibble_select && !hdlc_mode) |=> !rx_serial_payload_out)
    else $error("serial pin active with nibble select high");
endmodule
`default_nettype wire

// *** design/dtp_pkg.sv ***
// types for the terminal payload port
package dtp_pkg;
  typedef enum logic [1:0] {
    DTP_FMT_DS3,
    DTP_FMT_G832,
    DTP_FMT_G751
  } dtp_format_type;
endpackage

// *** dv/dtp_payload_port_tb_top.sv ***
// self-checking bench for the terminal payload port
`timescale 1ns/1ns
`default_nettype none
`include "dtp_map.svh"
module dtp_payload_port_tb_top;
  import dtp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hdlc = 1'b0, nib = 1'b0, line_t = 1'b0;
  logic ref_ck = 1'b0, line_ck = 1'b0, run = 1'b0, fcs_req = 1'b0;
  logic bv = 1'b0, bd = 1'b0, fs = 1'b0, pkt = 1'b0, good = 1'b0;
  dtp_format_type fmt = DTP_FMT_DS3;
  logic rxc, fcs, rdy, nck, fend, chkph, ser, idle, gpul, fbnd, gb, gf;
  logic [3:0] nibd;
  logic [1:0] exp_q[$];
  logic [1:0] e;
  logic [31:0] seed = 32'h0000002F;
  logic [10:0] last_cnt = 11'h000, ncnt = 11'h000;
  logic nck_d = 1'b0, fe_d = 1'b0;
  int n_got, nfr = 0, checked = 0, n_mismatch = 0, i, w, n0;
  always #4 clk = ~clk;
  // reference stops under line timing, so only the chosen source counts
  always #16 ref_ck = line_t ? 1'b0 : ~ref_ck;
  always #16 line_ck = ~line_ck;
  dtp_payload_port i_dut (.clk(clk), .rst(rst), .format_sel(fmt),
    .hdlc_mode(hdlc), .nibble_select(nib), .use_line_timing(line_t),
    .tx_reference_clock_in(ref_ck), .recovered_line_clock_in(line_ck),
    .send_check_sequence_in(fcs), .rx_payload_clock(rxc),
    .rx_bit_valid(bv), .rx_bit(bd), .rx_frame_start(fs),
    .rx_packet_active(pkt), .rx_check_good(good), .rx_bit_ready(rdy),
    .tx_nibble_clock_out(nck), .tx_frame_end_out(fend),
    .tx_check_phase_out(chkph), .rx_serial_payload_out(ser),
    .rx_hdlc_idle_flag_out(idle), .good_check_sequence_pulse(gpul),
    .rx_frame_boundary_out(fbnd), .rx_nibble_data_out(nibd));
  dtp_terminal_model i_partner (.run(run), .ser_in(ser), .frame_in(fbnd),
    .fcs_req(fcs_req), .rx_clk(rxc), .fcs_out(fcs), .got_bit(gb),
    .got_frame(gf), .n_got(n_got));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [10:0] x,
                     input logic [10:0] s);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", nm, x, s);
    end
  endtask
  task automatic close_out();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(n_got) begin
    if (exp_q.size() != 0) begin
      e = exp_q.pop_front();
      chk("serial_bit", e[0], gb);
      chk("frame_pulse", e[1], gf);
    end
  end
  // frame end may land with or just after the last nibble rise
  always @(posedge clk) begin
    nck_d <= nck;
    fe_d <= fend;
    if (rst) ncnt <= 11'h000;
    else if (fend && !fe_d) begin
      last_cnt <= ncnt + (nck && !nck_d);
      ncnt <= 11'h000;
      nfr <= nfr + 1;
    end else ncnt <= ncnt + (nck && !nck_d);
  end
  initial begin
    #760000;
    n_mismatch++;
    close_out();
  end
  initial begin
    step(8);
    rst = 1'b0;
    // serial: fill with partner stalled, then drain against it
    for (i = 0; i < 16; i++) begin
      if (i == 8) begin
        bv = 1'b0;
        step(1);
        chk("ready_full", 1'b0, rdy);
        run = 1'b1;
      end
      for (w = 0; w < 200 && rdy !== 1'b1; w++) step(1);
      seed = xs(seed);
      bv = 1'b1;
      bd = seed[0];
      fs = (i % 9 == 0);
      exp_q.push_back({fs, bd});
      step(1);
    end
    bv = 1'b0;
    for (w = 0; w < 400 && exp_q.size() != 0; w++) step(1);
    run = 1'b0;
    chk("drained", 11'h000, exp_q.size());
    nib = 1'b1;
    step(3);
    chk("ser_quiet", 1'b0, ser);
    nib = 1'b0;
    hdlc = 1'b1;
    for (i = 0; i < 12; i++) begin
      seed = xs(seed);
      pkt = seed[1];
      good = seed[2];
      step(1);
      chk("idle_flag", !pkt, idle);
      chk("ser_as_idle", !pkt, ser);
      chk("good_check", good, gpul);
    end
    fcs_req = 1'b1;
    for (w = 0; w < 10 && chkph !== 1'b1; w++) step(1);
    chk("check_phase", 1'b1, chkph);
    fcs_req = 1'b0;
    hdlc = 1'b0;
    nib = 1'b1;
    for (i = 0; i < 3; i++) begin
      fmt = dtp_format_type'(i);
      line_t = (i == 2);
      rst = 1'b1;
      step(8);
      rst = 1'b0;
      n0 = nfr;
      // first mark after reset ends a short frame; measure the next
      for (w = 0; w < 40000 && nfr < n0 + 2; w++) step(1);
      chk("nibble_edges", i == 0 ? `DTP_EDGES_DS3 : i == 1 ?
          `DTP_EDGES_G832 : `DTP_EDGES_G751, last_cnt);
    end
    close_out();
  end
endmodule
`default_nettype wire

// *** dv/dtp_terminal_model.sv ***
// terminal equipment model: receive clock, serial capture, send-fcs
`timescale 1ns/1ns
`default_nettype none
module dtp_terminal_model (
  input  wire logic run,
  input  wire logic ser_in,
  input  wire logic frame_in,
  input  wire logic fcs_req,
  output logic      rx_clk = 1'b0,
  output logic      fcs_out,
  output logic      got_bit = 1'b0,
  output logic      got_frame = 1'b0,
  output int        n_got = 0
);
  // clock stands low between bursts, finishes its high half first
  always #32 rx_clk = (run || rx_clk) ? ~rx_clk : 1'b0;
  // sampled on the fall: the bit launched by the rise has settled
  always @(negedge rx_clk) begin
    got_bit <= ser_in;
    got_frame <= frame_in;
    n_got <= n_got + 1;
  end
  assign fcs_out = fcs_req;
endmodule
`default_nettype wire
